// >>> rtl/fsr_pkg.sv
// Package holding constants for the suspend/resume sequencer
package fsr_pkg;
    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 10;
    localparam int SUSP_LAT_US = 40;
    // Longest time rounds down to whole cycles
    localparam int SUSP_LAT_CYC = SUSP_LAT_US * CLK_MHZ;
    localparam int RES_SUSP_US = 128;
    // Least time rounds up to whole cycles
    localparam int RES_SUSP_CYC = RES_SUSP_US * CLK_MHZ;
    localparam int CNT_W = 12;
    // Delay from suspend request to halt, well inside the latency bound
    localparam logic [11:0] HALT_CYC = 12'h0_010;
    // ----------------------------------------------------------------
    // Command codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_ERS_SUSP = 8'h75;
    localparam logic [7:0] CMD_ERS_RES = 8'h7A;
    localparam logic [7:0] CMD_PGM_SUSP = 8'h85;
    localparam logic [7:0] CMD_PGM_RES = 8'h8A;
    // ----------------------------------------------------------------
    // Parameter dword fields
    // ----------------------------------------------------------------
    localparam logic [0:0] SR_UNSUPP = 1'h0;
    localparam logic [1:0] ERS_LAT_UNIT = 2'h2;
    localparam logic [4:0] ERS_LAT_CNT = 5'h04;
    localparam logic [3:0] ERS_INT_CNT = 4'h1;
    localparam logic [1:0] PGM_LAT_UNIT = 2'h2;
    localparam logic [4:0] PGM_LAT_CNT = 5'h04;
    localparam logic [3:0] PGM_INT_CNT = 4'h1;
    localparam logic [0:0] RFU_BIT = 1'h1;
    localparam logic [3:0] ERS_PROHIB = 4'hE;
    localparam logic [3:0] PGM_PROHIB = 4'hC;
    // ----------------------------------------------------------------
    // Wishbone register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] ADR_CMD = 4'h0;
    localparam logic [3:0] ADR_STAT = 4'h4;
    localparam logic [3:0] ADR_PARAM = 4'h8;
    localparam logic [3:0] ADR_START = 4'hC;
    // Status bit positions
    localparam int ST_ERS_BUSY = 0;
    localparam int ST_ERS_SUSP = 1;
    localparam int ST_PGM_BUSY = 2;
    localparam int ST_PGM_SUSP = 3;
    localparam int ST_BAD_CMD = 4;
    // Operation phases
    typedef enum logic [2:0] {PH_IDLE, PH_RUN, PH_HALTING, PH_SUSP} fsr_phase_t;
endpackage : fsr_pkg

// >>> rtl/fsr_seq.sv
// Erase/program suspend and resume sequencer with Wishbone registers
`timescale 1ns/1ps
// Overview of operation
// - Erase halts within 40 us of suspend
// - Erase latency unit field reads 10b
// - Program halts within 40 us of suspend
// - Program latency unit field reads 10b
// - Erase-suspend prohibited field reads 1110b
// - Program-suspend prohibited field reads 1100b
// - Bit 31 reads 0: suspend supported
// - 75h erase suspend, 7Ah erase resume
// - 85h program suspend, 8Ah program resume
module fsr_seq
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Array operation status
    output logic ERASE_ACTIVE,
    output logic PROGRAM_ACTIVE
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        fsr_pkg::fsr_phase_t ers;   // Erase phase
        fsr_pkg::fsr_phase_t pgm;   // Program phase
        logic [11:0] ers_cnt;       // Erase halt delay / guard counter
        logic [11:0] pgm_cnt;       // Program halt delay / guard counter
        logic ers_guard;            // Erase resume-to-suspend window open
        logic pgm_guard;            // Program resume-to-suspend window open
        logic bad_cmd;              // Sticky refused-command flag
        logic ack;                  // Bus acknowledge
        logic [31:0] dat;           // Read data
    } fsr_state_t;

    fsr_state_t st;       // Registered state
    fsr_state_t next_st;  // Next state

    // Parameter dword, fixed by construction
    logic [31:0] param;
    assign param = {fsr_pkg::SR_UNSUPP,
                    fsr_pkg::ERS_LAT_UNIT,
                    fsr_pkg::ERS_LAT_CNT,
                    fsr_pkg::ERS_INT_CNT,
                    fsr_pkg::PGM_LAT_UNIT,
                    fsr_pkg::PGM_LAT_CNT,
                    fsr_pkg::PGM_INT_CNT,
                    fsr_pkg::RFU_BIT,
                    fsr_pkg::ERS_PROHIB,
                    fsr_pkg::PGM_PROHIB};

    // Qualified bus request; acked once, dropped the next cycle
    logic req;
    assign req = WB_CYC_I && WB_STB_I && !st.ack;
    logic wr;
    assign wr = req && WB_WE_I && WB_SEL_I[0];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.ack = req;
        // Halt counters: halt lands well inside the 40 us bound
        if (st.ers == fsr_pkg::PH_HALTING)
        begin
            if (st.ers_cnt == 12'h0_000)
                next_st.ers = fsr_pkg::PH_SUSP;
            else
                next_st.ers_cnt = st.ers_cnt - 12'h0_001;
        end
        else if (st.ers_guard)
        begin
            // Guard window after resume runs down
            if (st.ers_cnt == 12'h0_000)
                next_st.ers_guard = 1'b0;
            else
                next_st.ers_cnt = st.ers_cnt - 12'h0_001;
        end
        if (st.pgm == fsr_pkg::PH_HALTING)
        begin
            if (st.pgm_cnt == 12'h0_000)
                next_st.pgm = fsr_pkg::PH_SUSP;
            else
                next_st.pgm_cnt = st.pgm_cnt - 12'h0_001;
        end
        else if (st.pgm_guard)
        begin
            if (st.pgm_cnt == 12'h0_000)
                next_st.pgm_guard = 1'b0;
            else
                next_st.pgm_cnt = st.pgm_cnt - 12'h0_001;
        end
        // Command decode on a write to the command register
        if (wr && WB_ADR_I == fsr_pkg::ADR_CMD)
        begin
            case (WB_DAT_I[7:0])
                fsr_pkg::CMD_ERS_SUSP:
                begin
                    // Suspend inside the guard window is refused (host fault)
                    if (st.ers == fsr_pkg::PH_RUN && !st.ers_guard)
                    begin
                        next_st.ers = fsr_pkg::PH_HALTING;
                        next_st.ers_cnt = fsr_pkg::HALT_CYC;
                    end
                    else
                        next_st.bad_cmd = 1'b1;
                end
                fsr_pkg::CMD_ERS_RES:
                begin
                    if (st.ers == fsr_pkg::PH_SUSP)
                    begin
                        next_st.ers = fsr_pkg::PH_RUN;
                        next_st.ers_guard = 1'b1;
                        // Window closes in time for a suspend exactly 128 us after the resume edge
                        next_st.ers_cnt = 12'(fsr_pkg::RES_SUSP_CYC - 2);
                    end
                    else
                        next_st.bad_cmd = 1'b1;
                end
                fsr_pkg::CMD_PGM_SUSP:
                begin
                    if (st.pgm == fsr_pkg::PH_RUN && !st.pgm_guard)
                    begin
                        next_st.pgm = fsr_pkg::PH_HALTING;
                        next_st.pgm_cnt = fsr_pkg::HALT_CYC;
                    end
                    else
                        next_st.bad_cmd = 1'b1;
                end
                fsr_pkg::CMD_PGM_RES:
                begin
                    if (st.pgm == fsr_pkg::PH_SUSP)
                    begin
                        next_st.pgm = fsr_pkg::PH_RUN;
                        next_st.pgm_guard = 1'b1;
                        // Same window length as for erase
                        next_st.pgm_cnt = 12'(fsr_pkg::RES_SUSP_CYC - 2);
                    end
                    else
                        next_st.bad_cmd = 1'b1;
                end
                default:
                    next_st.bad_cmd = 1'b1;
            endcase
        end
        // Start/finish register: bit0 start erase, bit1 start program,
        // bit2 end erase, bit3 end program (stands in for the array)
        if (wr && WB_ADR_I == fsr_pkg::ADR_START)
        begin
            if (WB_DAT_I[0])
            begin
                // Nested erase refused while one exists
                if (st.ers == fsr_pkg::PH_IDLE)
                    next_st.ers = fsr_pkg::PH_RUN;
                else
                    next_st.bad_cmd = 1'b1;
            end
            if (WB_DAT_I[1])
            begin
                if (st.pgm == fsr_pkg::PH_IDLE)
                    next_st.pgm = fsr_pkg::PH_RUN;
                else
                    next_st.bad_cmd = 1'b1;
            end
            if (WB_DAT_I[2] && st.ers == fsr_pkg::PH_RUN)
            begin
                next_st.ers = fsr_pkg::PH_IDLE;
                next_st.ers_guard = 1'b0;
            end
            if (WB_DAT_I[3] && st.pgm == fsr_pkg::PH_RUN)
            begin
                next_st.pgm = fsr_pkg::PH_IDLE;
                next_st.pgm_guard = 1'b0;
            end
        end
        // Status write of 1 to bit 4 clears the refused flag
        if (wr && WB_ADR_I == fsr_pkg::ADR_STAT && WB_DAT_I[fsr_pkg::ST_BAD_CMD])
            next_st.bad_cmd = 1'b0;
        // Read mux; unmapped reads return zero
        next_st.dat = 32'h0000_0000;
        if (req && !WB_WE_I)
        begin
            case (WB_ADR_I)
                fsr_pkg::ADR_PARAM: next_st.dat = param;
                fsr_pkg::ADR_STAT:
                begin
                    next_st.dat[fsr_pkg::ST_ERS_BUSY] = st.ers != fsr_pkg::PH_IDLE;
                    next_st.dat[fsr_pkg::ST_ERS_SUSP] = st.ers == fsr_pkg::PH_SUSP;
                    next_st.dat[fsr_pkg::ST_PGM_BUSY] = st.pgm != fsr_pkg::PH_IDLE;
                    next_st.dat[fsr_pkg::ST_PGM_SUSP] = st.pgm == fsr_pkg::PH_SUSP;
                    next_st.dat[fsr_pkg::ST_BAD_CMD] = st.bad_cmd;
                end
                default: next_st.dat = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK or negedge NRST)
    begin
        if (!NRST)
            st <= '0;
        else
            st <= next_st;
    end

    // Outputs
    assign WB_ACK_O = st.ack;
    assign WB_DAT_O = st.dat;
    assign ERASE_ACTIVE = st.ers == fsr_pkg::PH_RUN || st.ers == fsr_pkg::PH_HALTING;
    assign PROGRAM_ACTIVE = st.pgm == fsr_pkg::PH_RUN || st.pgm == fsr_pkg::PH_HALTING;
endmodule // fsr_seq

// >>> verification/fsr_seq_assertions.sv
// Checker for the suspend sequencer bus and status ports
`timescale 1ns/1ps
module fsr_seq_chk
(
    // Clock and reset
    input wire logic CLOCK,
    input wire logic NRST,
    // Wishbone slave side
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [3:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Array status
    input wire logic ERASE_ACTIVE,
    input wire logic PROGRAM_ACTIVE
);
    // Request taken at this edge
    logic take;
    // Command write, low byte only
    logic cmd;
    // A parameter read waits for its answer
    logic rd_par;
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign cmd = take && WB_WE_I && WB_SEL_I[0] && WB_ADR_I == fsr_pkg::ADR_CMD;
    // Tracks parameter reads so field checks only look at that answer
    always_ff @(posedge CLOCK or negedge NRST)
        if (!NRST) rd_par <= 1'b0;
        else rd_par <= take && !WB_WE_I && WB_ADR_I == fsr_pkg::ADR_PARAM;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    a_ack_next: assert property (take |=> WB_ACK_O) else $error("ack missing");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
    a_sr_flag: assert property (rd_par && WB_ACK_O |-> WB_DAT_O[31] == 1'b0) else $error("bit31");
    a_ers_fields: assert property (rd_par && WB_ACK_O |-> WB_DAT_O[30:20] == 11'h441)
        else $error("erase fields");
    a_pgm_fields: assert property (rd_par && WB_ACK_O |-> WB_DAT_O[19:9] == 11'h441)
        else $error("program fields");
    a_rfu_bit: assert property (rd_par && WB_ACK_O |-> WB_DAT_O[8]) else $error("reserved bit");
    a_prohib_fields: assert property (rd_par && WB_ACK_O |-> WB_DAT_O[7:0] == 8'hEC)
        else $error("prohibited fields");
    a_ers_halt: assert property (cmd && WB_DAT_I[7:0] == 8'h75 && ERASE_ACTIVE |-> ##[1:400] !ERASE_ACTIVE)
        else $error("erase not halted");
    a_pgm_halt: assert property (cmd && WB_DAT_I[7:0] == 8'h85 && PROGRAM_ACTIVE |-> ##[1:400] !PROGRAM_ACTIVE)
        else $error("program not halted");
    // Main scenarios seen
    c_par_read: cover property (rd_par && WB_ACK_O);
    c_ers_halt: cover property ($fell(ERASE_ACTIVE));
    c_pgm_halt: cover property ($fell(PROGRAM_ACTIVE));
endmodule // fsr_seq_chk
bind fsr_seq fsr_seq_chk i_fsr_seq_chk (.CLOCK(CLOCK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .ERASE_ACTIVE(ERASE_ACTIVE), .PROGRAM_ACTIVE(PROGRAM_ACTIVE));

// >>> verification/fsr_host.sv
// Host controller model issuing classic Wishbone cycles
`timescale 1ns/1ps
module fsr_host
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Request from the bench, held until done
    input wire logic go,
    input wire logic we,
    input wire logic [3:0] adr,
    input wire logic [31:0] dat,
    output logic [31:0] rdat,
    output logic done,
    // Wishbone master side
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc,
    output logic stb,
    output logic we_o,
    output logic [3:0] adr_o,
    output logic [3:0] sel,
    output logic [31:0] dat_o
);
    // One cycle at a time; released lines show inverted data so no stale value looks valid
    always_ff @(posedge clock or negedge nrst)
        if (!nrst) {cyc, stb, we_o, adr_o, sel, dat_o, rdat, done} <= '0;
        else if (cyc && ack_i)
        begin
            {cyc, stb} <= 2'b00;
            rdat <= dat_i;
            dat_o <= ~dat_o;
            done <= 1'b1;
        end
        else
        begin
            done <= 1'b0;
            // The done guard stops a second start before the bench drops go
            if (go && !cyc && !done) {cyc, stb, we_o, adr_o, sel, dat_o} <= {2'b11, we, adr, 4'hF, dat};
        end
endmodule // fsr_host

// >>> verification/tb.sv
// Testbench for the suspend sequencer
`timescale 1ns/1ps
module tb;
    logic clock, nrst, go, we, done, cyc, stb, wwe, ack, ea, pa;
    logic [3:0] adr, wadr, sel;
    logic [31:0] dat, rdat, wdat, dout;
    int err_total, n_tests, cyc_n;
    fsr_seq i_fsr_seq (.CLOCK(clock), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(wwe), .WB_ADR_I(wadr),
        .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dout), .WB_ACK_O(ack), .ERASE_ACTIVE(ea), .PROGRAM_ACTIVE(pa));
    fsr_host i_fsr_host (.clock(clock), .nrst(nrst), .go(go), .we(we), .adr(adr), .dat(dat), .rdat(rdat),
        .done(done), .ack_i(ack), .dat_i(dout), .cyc(cyc), .stb(stb), .we_o(wwe), .adr_o(wadr), .sel(sel), .dat_o(wdat));
    // Verdict and end of run
    task test_done;
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Value compare
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle through the host model; go stays up until done is seen
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        {go, we, adr, dat} <= {1'b1, w, a, d};
        do @(negedge clock); while (done !== 1'b1);
        @(posedge clock);
        go <= 1'b0;
    endtask
    // Status read and compare
    task stat(input logic [31:0] e);
        wb(1'b0, 4'h4, 32'h0000_0000);
        chk(rdat, e);
    endtask
    // Halt time compare; two cycles already passed since the request edge
    task halt(input logic k);
        int n;
        n = 0;
        while ((k ? pa : ea) !== 1'b0 && n < 500)
        begin
            @(negedge clock);
            n++;
        end
        chk(32'(n <= 399), 32'h0000_0001);
    endtask
    // Suspend, resume, wait out the interval, suspend again, then finish
    task susp(input logic k, input logic [7:0] s, input logic [7:0] r, input logic [31:0] run, input logic [31:0] hold);
        wb(1'b1, 4'hC, k ? 32'h0000_0002 : 32'h0000_0001);
        stat(run);
        wb(1'b1, 4'h0, {24'h0, s});
        halt(k);
        stat(hold);
        // A nested start while suspended is refused and flagged, state kept
        wb(1'b1, 4'hC, k ? 32'h0000_0002 : 32'h0000_0001);
        stat(hold | 32'h0000_0010);
        wb(1'b1, 4'h4, 32'h0000_0010);
        stat(hold);
        wb(1'b1, 4'h0, {24'h0, r});
        stat(run);
        // No read during the wait, and a full interval before suspending again
        repeat (1280) @(posedge clock);
        wb(1'b1, 4'h0, {24'h0, s});
        halt(k);
        stat(hold);
        wb(1'b1, 4'h0, {24'h0, r});
        wb(1'b1, 4'hC, k ? 32'h0000_0008 : 32'h0000_0004);
        stat(32'h0000_0000);
    endtask
    // Parameter dword, then a write that must not change it
    task t_param;
        wb(1'b0, 4'h8, 32'h0000_0000);
        chk(rdat, 32'h4418_83EC);
        wb(1'b1, 4'h8, 32'h0000_0000);
        wb(1'b0, 4'h8, 32'h0000_0000);
        chk(rdat, 32'h4418_83EC);
    endtask
    task t_erase;
        susp(1'b0, 8'h75, 8'h7A, 32'h0000_0001, 32'h0000_0003);
    endtask
    task t_pgm;
        susp(1'b1, 8'h85, 8'h8A, 32'h0000_0004, 32'h0000_000C);
    endtask
    // Unknown code is refused and flagged; write one clears the flag
    task t_bad;
        wb(1'b1, 4'h0, 32'h0000_0000);
        stat(32'h0000_0010);
        wb(1'b1, 4'h4, 32'h0000_0010);
        stat(32'h0000_0000);
    endtask
    // Clock and hang guard
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc_n++;
        if (cyc_n == 20000)
        begin
            err_total++;
            test_done;
        end
    end
    // Main sequence
    initial
    begin
        {nrst, go, we, adr, dat} = '0;
        {err_total, n_tests, cyc_n} = '0;
        repeat (4) @(posedge clock);
        nrst <= 1'b1;
        t_param;
        t_erase;
        t_pgm;
        t_bad;
        test_done;
    end
endmodule // tb
